/* design/eeprom_pkg.sv */
// shared constants and types for the two-wire eeprom write path
package eeprom_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int MCLK_HZ         = 200_000_000;
  localparam int MCLK_PER_US     = MCLK_HZ / 1_000_000;
  // program_cycle_time, longest, in microseconds
  localparam int PROGRAM_TIME_US = 10_000;
  localparam int PROG_CYCLES     = PROGRAM_TIME_US * MCLK_PER_US;
  localparam int SCL_FREQ_KHZ    = 400;
  localparam int QUARTER_CYCLES  = MCLK_HZ / (SCL_FREQ_KHZ * 1000 * 4);

  // ****************************************
  // array and protocol layout
  // ****************************************
  localparam int         ADDR_W     = 7;
  localparam int         MEM_BYTES  = 128;
  localparam int         PAGE_BYTES = 8;
  localparam int         PAGE_W     = 3;
  localparam logic [3:0] DATA_BITS  = 4'h8;
  localparam logic [3:0] DEV_TYPE   = 4'hA;
  localparam logic [7:0] ERASED     = 8'hFF;
  localparam int         DIR_BIT    = 0;

  // ****************************************
  // host command set
  // ****************************************
  typedef enum logic [1:0] {OP_START, OP_STOP, OP_BYTE} host_op_t;
endpackage

/* design/two_wire_if.sv */
// open-drain two-wire bus joining the master and the eeprom
interface two_wire_if;
  logic scl_o_m;
  logic scl_oe_m;
  logic sda_o_m;
  logic sda_oe_m;
  logic sda_o_s;
  logic sda_oe_s;
  logic scl;
  logic sda;

  // ****************************************
  // wired-and with pull-ups
  // ****************************************
  assign scl = !(scl_oe_m && !scl_o_m);
  assign sda = !((sda_oe_m && !sda_o_m) || (sda_oe_s && !sda_o_s));

  modport device (input scl, input sda, output sda_o_s, output sda_oe_s);
  modport master (input scl, input sda, output scl_o_m, output scl_oe_m,
                  output sda_o_m, output sda_oe_m);
endinterface

/* design/line_sampler.sv */
// two-flop synchroniser and edge finder for the bus lines
module line_sampler
(
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o,
  output logic      scl_rise_o,
  output logic      scl_fall_o,
  output logic      sda_rise_o,
  output logic      sda_fall_o
);
  logic [1:0] meta;
  logic [1:0] sync;
  logic [1:0] prev;

  // lines idle high, so reset to high avoids a false edge
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      meta <= 2'h3;
      sync <= 2'h3;
      prev <= 2'h3;
    end
    else
    begin
      meta <= {scl_i, sda_i};
      sync <= meta;
      prev <= sync;
    end
  end

  assign scl_o      = sync[1];
  assign sda_o      = sync[0];
  assign scl_rise_o = sync[1] && !prev[1];
  assign scl_fall_o = !sync[1] && prev[1];
  assign sda_rise_o = sync[0] && !prev[0];
  assign sda_fall_o = !sync[0] && prev[0];
endmodule

/* design/eeprom_slave.sv */
// eeprom end: start/stop, select, address, page latch, program cycle
module eeprom_slave
#(
  parameter int PROG_CYCLES       = eeprom_pkg::PROG_CYCLES,
  parameter bit HAS_WRITE_CONTROL = 1'b0
)
(
  two_wire_if.device                         bus,
  input  wire logic                          mclk_i,
  input  wire logic                          rstn_i,
  input  wire logic                          aux_clock_write_enable_i,
  input  wire logic                          write_protect_control_i,
  input  wire logic [eeprom_pkg::ADDR_W-1:0] peek_addr_i,
  output logic      [7:0]                    peek_data_o,
  output logic      [eeprom_pkg::ADDR_W-1:0] addr_count_o,
  output logic                               busy_o
);
  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_SELECT,
    ST_ADDR,
    ST_DATA,
    ST_READ,
    ST_PROGRAM
  } state_t;

  state_t                              state;
  logic   [3:0]                        bit_cnt;
  logic                                ack_phase;
  logic   [7:0]                        shift;
  logic                                sda_pull;
  logic   [eeprom_pkg::ADDR_W-1:0]     addr;
  logic   [7:0]                        page_data [eeprom_pkg::PAGE_BYTES];
  logic   [eeprom_pkg::PAGE_BYTES-1:0] page_valid;
  logic   [7:0]                        mem [eeprom_pkg::MEM_BYTES];
  logic   [31:0]                       timer;
  logic   [1:0]                        aux_sync;
  logic   [1:0]                        wpc_sync;
  logic                                write_enable;
  logic                                scl;
  logic                                sda;
  logic                                scl_rise;
  logic                                scl_fall;
  logic                                sda_rise;
  logic                                sda_fall;
  logic                                start_seen;
  logic                                stop_seen;
  logic                                byte_done;
  logic                                prog_end;

  // ****************************************
  // line sampling and conditions
  // ****************************************
  line_sampler u_lines
  (
    .mclk_i     (mclk_i),
    .rstn_i     (rstn_i),
    .scl_i      (bus.scl),
    .sda_i      (bus.sda),
    .scl_o      (scl),
    .sda_o      (sda),
    .scl_rise_o (scl_rise),
    .scl_fall_o (scl_fall),
    .sda_rise_o (sda_rise),
    .sda_fall_o (sda_fall)
  );

  assign start_seen = scl && sda_fall;
  assign stop_seen  = scl && sda_rise;
  assign prog_end   = (timer == PROG_CYCLES - 1);

  // byte complete: eighth bit in, first falling edge after it
  assign byte_done = (state != ST_IDLE) && (state != ST_PROGRAM) &&
                     !start_seen && !stop_seen && scl_fall &&
                     !ack_phase && (bit_cnt == eeprom_pkg::DATA_BITS);

  // ****************************************
  // write enable pins
  // ****************************************
  // pull-down on the write control pin lives outside, not in logic
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      aux_sync <= 2'h0;
      wpc_sync <= 2'h0;
    end
    else
    begin
      aux_sync <= {aux_sync[0], aux_clock_write_enable_i};
      wpc_sync <= {wpc_sync[0], write_protect_control_i};
    end
  end

  assign write_enable = HAS_WRITE_CONTROL ? wpc_sync[1]
                                          : aux_sync[1];

  // ****************************************
  // protocol state machine
  // ****************************************
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      state     <= ST_IDLE;
      bit_cnt   <= 4'h0;
      ack_phase <= 1'b0;
      shift     <= 8'h00;
      sda_pull  <= 1'b0;
    end
    else if (state == ST_PROGRAM)
    begin
      // bus is not looked at at all, so a poll goes unanswered
      sda_pull <= 1'b0;
      if (prog_end)
        state <= ST_IDLE;
    end
    else if (start_seen)
    begin
      state     <= ST_SELECT;
      bit_cnt   <= 4'h0;
      ack_phase <= 1'b0;
      sda_pull  <= 1'b0;
    end
    else if (stop_seen)
    begin
      sda_pull <= 1'b0;
      if (state == ST_DATA && |page_valid)
        state <= ST_PROGRAM;
      else
        state <= ST_IDLE;
    end
    else if (state != ST_IDLE && scl_rise && !ack_phase &&
             bit_cnt != eeprom_pkg::DATA_BITS)
    begin
      shift   <= {shift[6:0], sda};
      bit_cnt <= bit_cnt + 4'h1;
    end
    else if (byte_done)
    begin
      ack_phase <= 1'b1;
      case (state)
        ST_SELECT:
        begin
          if (shift[7:4] == eeprom_pkg::DEV_TYPE)
          begin
            sda_pull <= 1'b1;
            state    <= shift[eeprom_pkg::DIR_BIT] ? ST_READ
                                                   : ST_ADDR;
          end
          else
            state <= ST_IDLE;
        end
        ST_ADDR:
        begin
          sda_pull <= 1'b1;
          state    <= ST_DATA;
        end
        ST_DATA:
          sda_pull <= 1'b1;
        default:
          sda_pull <= 1'b0;
      endcase
    end
    else if (state != ST_IDLE && scl_fall && ack_phase)
    begin
      sda_pull  <= 1'b0;
      ack_phase <= 1'b0;
      bit_cnt   <= 4'h0;
    end
  end

  // ****************************************
  // address counter and page latches
  // ****************************************
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      addr       <= '0;
      page_valid <= '0;
    end
    else if (state == ST_PROGRAM)
    begin
      if (prog_end)
        page_valid <= '0;
    end
    else if (start_seen)
      page_valid <= '0;
    else if (byte_done && state == ST_ADDR)
      addr <= shift[eeprom_pkg::ADDR_W-1:0];
    else if (byte_done && state == ST_DATA)
    begin
      if (write_enable)
      begin
        page_data[addr[eeprom_pkg::PAGE_W-1:0]]  <= shift;
        page_valid[addr[eeprom_pkg::PAGE_W-1:0]] <= 1'b1;
      end
      // row bits stay put, so a long page wraps and overwrites
      addr[eeprom_pkg::PAGE_W-1:0] <=
        addr[eeprom_pkg::PAGE_W-1:0] + 3'h1;
    end
  end

  // ****************************************
  // program timer and array
  // ****************************************
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i || state != ST_PROGRAM)
      timer <= 32'h0;
    else
      timer <= timer + 32'h1;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < eeprom_pkg::MEM_BYTES; i++)
        mem[i] <= eeprom_pkg::ERASED;
    end
    else if (state == ST_PROGRAM && prog_end)
    begin
      for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++)
        if (page_valid[i])
          mem[{addr[eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_W],
               i[eeprom_pkg::PAGE_W-1:0]}] <= page_data[i];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
      peek_data_o <= 8'h00;
    else
      peek_data_o <= mem[peek_addr_i];
  end

  // ****************************************
  // outputs
  // ****************************************
  // only ever pulls data low; the clock is never touched
  assign bus.sda_o_s  = 1'b0;
  assign bus.sda_oe_s = sda_pull;
  assign addr_count_o = addr;
  assign busy_o       = (state == ST_PROGRAM);
endmodule

/* design/eeprom_master.sv */
// bus master end: start, stop and byte transfers with ack capture
module eeprom_master
#(
  parameter int QUARTER = eeprom_pkg::QUARTER_CYCLES
)
(
  two_wire_if.master              bus,
  input  wire logic               mclk_i,
  input  wire logic               rstn_i,
  input  wire logic               cmd_valid_i,
  input  eeprom_pkg::host_op_t    cmd_op_i,
  input  wire logic [7:0]         cmd_data_i,
  output logic                    cmd_ready_o,
  output logic                    done_o,
  output logic                    ack_o
);
  typedef enum logic [1:0] {H_IDLE, H_START, H_STOP, H_BYTE} hstate_t;

  hstate_t     state;
  logic [15:0] qcnt;
  logic        tick;
  logic [1:0]  phase;
  logic [3:0]  bit_idx;
  logic [7:0]  tx;
  logic        scl_pull;
  logic        sda_pull;
  logic        sda;

  line_sampler u_lines
  (
    .mclk_i     (mclk_i),
    .rstn_i     (rstn_i),
    .scl_i      (bus.scl),
    .sda_i      (bus.sda),
    .scl_o      (),
    .sda_o      (sda),
    .scl_rise_o (),
    .scl_fall_o (),
    .sda_rise_o (),
    .sda_fall_o ()
  );

  // ****************************************
  // quarter-bit divider
  // ****************************************
  assign tick = (state != H_IDLE) && (qcnt == 16'(QUARTER - 1));

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i || state == H_IDLE || tick)
      qcnt <= 16'h0;
    else
      qcnt <= qcnt + 16'h1;
  end

  // ****************************************
  // bus sequencer
  // ****************************************
  // in a byte, data only moves while the clock is low; start and stop move it with the clock high
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      state    <= H_IDLE;
      phase    <= 2'h0;
      bit_idx  <= 4'h0;
      tx       <= 8'h00;
      scl_pull <= 1'b0;
      sda_pull <= 1'b0;
      done_o   <= 1'b0;
      ack_o    <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (state == H_IDLE && cmd_valid_i)
      begin
        phase   <= 2'h0;
        bit_idx <= 4'h0;
        tx      <= cmd_data_i;
        case (cmd_op_i)
          eeprom_pkg::OP_START: state <= H_START;
          eeprom_pkg::OP_STOP:  state <= H_STOP;
          default:              state <= H_BYTE;
        endcase
      end
      else if (tick)
      begin
        phase <= phase + 2'h1;
        case (state)
          H_START:
          begin
            if (phase == 2'h0)
              sda_pull <= 1'b0;
            else if (phase == 2'h1)
              scl_pull <= 1'b0;
            else if (phase == 2'h2)
              sda_pull <= 1'b1;
            else
            begin
              scl_pull <= 1'b1;
              state    <= H_IDLE;
              done_o   <= 1'b1;
            end
          end
          H_STOP:
          begin
            if (phase == 2'h0)
              sda_pull <= 1'b1;
            else if (phase == 2'h1)
              scl_pull <= 1'b0;
            else if (phase == 2'h2)
              sda_pull <= 1'b0;
            else
            begin
              state  <= H_IDLE;
              done_o <= 1'b1;
            end
          end
          H_BYTE:
          begin
            if (phase == 2'h0)
              sda_pull <= (bit_idx != eeprom_pkg::DATA_BITS) &&
                          !tx[7];
            else if (phase == 2'h1)
              scl_pull <= 1'b0;
            else if (phase == 2'h2)
            begin
              if (bit_idx == eeprom_pkg::DATA_BITS)
                ack_o <= !sda;
            end
            else
            begin
              scl_pull <= 1'b1;
              tx       <= {tx[6:0], 1'b0};
              bit_idx  <= bit_idx + 4'h1;
              if (bit_idx == eeprom_pkg::DATA_BITS)
              begin
                state  <= H_IDLE;
                done_o <= 1'b1;
              end
            end
          end
          default:
            state <= H_IDLE;
        endcase
      end
    end
  end

  assign cmd_ready_o  = (state == H_IDLE);
  assign bus.scl_o_m  = 1'b0;
  assign bus.scl_oe_m = scl_pull;
  assign bus.sda_o_m  = 1'b0;
  assign bus.sda_oe_m = sda_pull;
endmodule

/* verification/eeprom_link_monitor.sv */
// assertions on the two-wire link between master and eeprom
module eeprom_link_monitor
#(
  parameter int PROG_CYCLES = 2000
)
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_oe_m,
  input wire logic sda_o_s,
  input wire logic sda_oe_s,
  input wire logic busy_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       prev_scl;
  logic       prev_sda;
  logic       framed;
  logic [3:0] bit_cnt;
  logic [7:0] since_stop;
  int         busy_cnt;
  logic       start_seen;
  logic       stop_seen;

  // **********
  // bus event tracking
  // **********
  assign start_seen = scl && prev_scl && prev_sda && !sda;
  assign stop_seen  = scl && prev_scl && !prev_sda && sda;

  always_ff @(posedge mclk_i)
  begin
    prev_scl <= rstn_i ? scl : 1'b1;
    prev_sda <= rstn_i ? sda : 1'b1;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i || stop_seen)
      framed <= 1'b0;
    else if (start_seen)
      framed <= 1'b1;
  end

  // ninth rise wraps to zero, so ack belongs to count eight
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i || start_seen)
      bit_cnt <= 4'h0;
    else if (framed && scl && !prev_scl)
      bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i || stop_seen)
      since_stop <= 8'h00;
    else if (since_stop != 8'hFF)
      since_stop <= since_stop + 8'h01;
  end

  always_ff @(posedge mclk_i)
  begin
    busy_cnt <= (!rstn_i || !busy_o) ? 0 : busy_cnt + 1;
  end

  // **********
  // properties
  // **********
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_ack_clock;
    ##[1:64] $rose(scl);
  endsequence
  sequence s_ack_release;
    ##[1:64] $fell(scl) ##[2:4] $fell(sda_oe_s);
  endsequence

  a_ack_low_clock: assert property ($rose(sda_oe_s) |-> !scl)
    else $error("ack raised while clock high");
  a_ack_ninth_bit: assert property ($rose(sda_oe_s) |-> bit_cnt == 4'h8)
    else $error("ack outside the ninth bit");
  a_ack_held: assert property ($rose(sda_oe_s) |-> sda_oe_s throughout s_ack_clock)
    else $error("ack dropped before the clock rose");
  a_ack_window: assert property ($rose(sda_oe_s) |-> s_ack_clock ##0 s_ack_release)
    else $error("ack not released after ninth pulse");
  a_silent_idle: assert property (!framed |-> !sda_oe_s)
    else $error("data pulled outside a frame");
  a_busy_silent: assert property (busy_o |-> !sda_oe_s)
    else $error("answer during program cycle");
  a_busy_after_stop: assert property ($rose(busy_o) |-> since_stop <= 8'h08)
    else $error("program cycle without a stop");
  a_busy_length: assert property ($fell(busy_o) |->
    busy_cnt >= PROG_CYCLES - 1 && busy_cnt <= PROG_CYCLES + 1)
    else $error("program cycle length wrong");
  a_clock_master: assert property ($fell(scl) |-> scl_oe_m)
    else $error("clock pulled by someone else");
  a_drain_only: assert property (sda_oe_s |-> !sda_o_s && !sda)
    else $error("eeprom pull not seen low on data");
endmodule

/* verification/i2c_eeprom_slave_write_path_tb_top.sv */
// self-checking bench joining master and eeprom across the link
module i2c_eeprom_slave_write_path_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PROG = 2000;
  localparam int QTR  = 8;
  logic                 mclk_i;
  logic                 rstn_i;
  logic                 cmd_valid;
  eeprom_pkg::host_op_t cmd_op;
  logic [7:0]           cmd_data;
  logic                 cmd_ready;
  logic                 done;
  logic                 ack;
  logic                 aux_we;
  logic [6:0]           peek_addr;
  logic [7:0]           peek_data;
  logic [6:0]           addr_count;
  logic                 busy;
  int                   errors;
  int                   check_count;

  two_wire_if bus_if ();

  // write control input unused with the aux pin variant
  eeprom_slave #(.PROG_CYCLES(PROG)) eeprom_slave_inst
  (
    .bus                      (bus_if),
    .mclk_i                   (mclk_i),
    .rstn_i                   (rstn_i),
    .aux_clock_write_enable_i (aux_we),
    .write_protect_control_i  (1'b0),
    .peek_addr_i              (peek_addr),
    .peek_data_o              (peek_data),
    .addr_count_o             (addr_count),
    .busy_o                   (busy)
  );

  eeprom_master #(.QUARTER(QTR)) eeprom_master_inst
  (
    .bus         (bus_if),
    .mclk_i      (mclk_i),
    .rstn_i      (rstn_i),
    .cmd_valid_i (cmd_valid),
    .cmd_op_i    (cmd_op),
    .cmd_data_i  (cmd_data),
    .cmd_ready_o (cmd_ready),
    .done_o      (done),
    .ack_o       (ack)
  );

  eeprom_link_monitor #(.PROG_CYCLES(PROG)) eeprom_link_monitor_inst
  (
    .mclk_i   (mclk_i),
    .rstn_i   (rstn_i),
    .scl      (bus_if.scl),
    .sda      (bus_if.sda),
    .scl_oe_m (bus_if.scl_oe_m),
    .sda_o_s  (bus_if.sda_o_s),
    .sda_oe_s (bus_if.sda_oe_s),
    .busy_o   (busy)
  );

  // **********
  // shared tasks
  // **********
  task automatic compare(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("BAD at %0t got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask

  // bounded waits; a hang shows up as done missing
  task automatic send(input eeprom_pkg::host_op_t op, input logic [7:0] d);
    int n;
    @(posedge mclk_i);
    #1;
    cmd_valid = 1'b1;
    cmd_op    = op;
    cmd_data  = d;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 1000)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    @(posedge mclk_i);
    #1;
    cmd_valid = 1'b0;
    compare({7'h00, cmd_ready}, 8'h00);
    while (done !== 1'b1 && n < 1000)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    compare({7'h00, done}, 8'h01);
  endtask

  task automatic peek_check(input logic [6:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    #1;
    peek_addr = a;
    repeat (2) @(posedge mclk_i);
    #1;
    compare(peek_data, exp);
  endtask

  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (busy !== lvl && n < lim)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    compare({7'h00, busy}, {7'h00, lvl});
  endtask

  task automatic head(input logic [6:0] a);
    send(eeprom_pkg::OP_START, 8'h00);
    send(eeprom_pkg::OP_BYTE, 8'hA0);
    compare({7'h00, ack}, 8'h01);
    send(eeprom_pkg::OP_BYTE, {1'b0, a});
    compare({7'h00, ack}, 8'h01);
  endtask

  // **********
  // scenarios
  // **********
  task automatic test_reset;
    compare({7'h00, busy}, 8'h00);
    compare({1'b0, addr_count}, 8'h00);
    peek_check(7'h00, 8'hFF);
    peek_check(7'h7F, 8'hFF);
  endtask

  task automatic test_select;
    logic [7:0] code [4];
    logic [7:0] want [4];
    code = '{8'hAE, 8'hA1, 8'hB0, 8'h2E};
    want = '{8'h01, 8'h01, 8'h00, 8'h00};
    for (int i = 0; i < 4; i++)
    begin
      send(eeprom_pkg::OP_START, 8'h00);
      send(eeprom_pkg::OP_BYTE, code[i]);
      compare({7'h00, ack}, want[i]);
      send(eeprom_pkg::OP_STOP, 8'h00);
      repeat (8) @(posedge mclk_i);
      #1;
      compare({7'h00, busy}, 8'h00);
    end
  endtask

  task automatic test_byte_poll;
    int n;
    head(7'h15);
    send(eeprom_pkg::OP_BYTE, 8'h5A);
    compare({7'h00, ack}, 8'h01);
    send(eeprom_pkg::OP_STOP, 8'h00);
    wait_busy(1'b1, 20);
    send(eeprom_pkg::OP_START, 8'h00);
    send(eeprom_pkg::OP_BYTE, 8'hA0);
    compare({7'h00, ack}, 8'h00);
    n = 0;
    while (ack !== 1'b1 && n < 20)
    begin
      send(eeprom_pkg::OP_START, 8'h00);
      send(eeprom_pkg::OP_BYTE, 8'hA0);
      n++;
    end
    compare({7'h00, ack}, 8'h01);
    compare({7'h00, busy}, 8'h00);
    send(eeprom_pkg::OP_STOP, 8'h00);
    peek_check(7'h15, 8'h5A);
    compare({1'b0, addr_count}, 8'h16);
  endtask

  // start two short of the row end so the counter wraps
  task automatic test_page_wrap;
    logic [6:0] pa [5];
    logic [7:0] pd [5];
    pa = '{7'h1E, 7'h1F, 7'h18, 7'h19, 7'h1A};
    pd = '{8'h11, 8'h22, 8'h33, 8'h44, 8'hFF};
    head(7'h1E);
    for (int i = 0; i < 4; i++)
    begin
      send(eeprom_pkg::OP_BYTE, pd[i]);
      compare({7'h00, ack}, 8'h01);
    end
    send(eeprom_pkg::OP_STOP, 8'h00);
    wait_busy(1'b1, 20);
    wait_busy(1'b0, PROG + 20);
    for (int i = 0; i < 5; i++)
      peek_check(pa[i], pd[i]);
    compare({1'b0, addr_count}, 8'h1A);
  endtask

  task automatic test_inhibit;
    aux_we = 1'b0;
    head(7'h40);
    send(eeprom_pkg::OP_BYTE, 8'h33);
    compare({7'h00, ack}, 8'h01);
    send(eeprom_pkg::OP_STOP, 8'h00);
    repeat (20) @(posedge mclk_i);
    #1;
    compare({7'h00, busy}, 8'h00);
    peek_check(7'h40, 8'hFF);
    compare({1'b0, addr_count}, 8'h41);
    aux_we = 1'b1;
  endtask

  task automatic give_verdict;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // **********
  // clock, sequence, watchdog
  // **********
  initial
  begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  initial
  begin
    rstn_i      = 1'b0;
    cmd_valid   = 1'b0;
    cmd_op      = eeprom_pkg::OP_START;
    cmd_data    = 8'h00;
    aux_we      = 1'b1;
    peek_addr   = 7'h00;
    errors      = 0;
    check_count = 0;
    repeat (2) @(posedge mclk_i);
    #1;
    rstn_i = 1'b1;
    test_reset();
    test_select();
    test_byte_poll();
    test_page_wrap();
    test_inhibit();
    give_verdict();
  end

  // about four times the expected run
  initial
  begin
    #200000;
    errors++;
    give_verdict();
  end
endmodule
